// file: design/abslc_defines.vh
// constants for the autobaud serial link configuration block
`ifndef ABSLC_DEFINES_VH
`define ABSLC_DEFINES_VH

`define ABSLC_CLK_HZ          125000000
`define ABSLC_SETTLE_TIME_S   15
`define ABSLC_LED_SLOT_MS     250
`define ABSLC_SETTLE_CYCLES   (`ABSLC_SETTLE_TIME_S * `ABSLC_CLK_HZ)
`define ABSLC_LED_SLOT_CYCLES ((`ABSLC_LED_SLOT_MS * (`ABSLC_CLK_HZ / 1000)))

`define ABSLC_ADDR_MIN        8'h01
`define ABSLC_ADDR_MAX        8'h7F
`define ABSLC_DATA_BITS       3'h7
`define ABSLC_DIV_MIN         16'h0010
`define ABSLC_DIV_NONE        16'hFFFF
`define ABSLC_OID_PREFIX      22'h0186A0 // vendor prefix; the value is arbitrary
`define ABSLC_LED_INVALID     2'h1
`define ABSLC_LED_LEARN       2'h2
`define ABSLC_LED_NONE        2'h0

`endif

// file: design/abslc_pulse_meter.v
// shortest line pulse meter used to learn the bit time
`include "abslc_defines.vh"

module abslc_pulse_meter (
	input  wire        clk,
	input  wire        rstn,
	input  wire        rx_s,
	input  wire        clear,
	input  wire        enable,
	output reg  [15:0] min_width_q
);

	reg        prev_q;
	reg [15:0] cnt_q;

	// the shortest pulse seen on the line is one bit time
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prev_q      <= 1'b1;
			cnt_q       <= 16'hFFFF;
			min_width_q <= `ABSLC_DIV_NONE;
		end else if (clear) begin
			// idle time before the first edge is not a bit, so start saturated
			prev_q      <= rx_s;
			cnt_q       <= 16'hFFFF;
			min_width_q <= `ABSLC_DIV_NONE;
		end else begin
			prev_q <= rx_s;
			if (rx_s != prev_q) begin
				cnt_q <= 16'h0001;
				// glitches below the floor are not taken as bits
				if (enable && cnt_q >= `ABSLC_DIV_MIN && cnt_q < min_width_q)
					min_width_q <= cnt_q;
			end else if (cnt_q != 16'hFFFF) begin
				cnt_q <= cnt_q + 16'h0001;
			end
		end
	end

endmodule

// file: design/abslc_link_cfg.v
// autobaud serial link configuration front end
// Behaviour
// - characters are 8 data bits, no parity, one stop bit only
// - bit rate is learned from observed line traffic, not preset
// - power-up with valid address starts monitoring the line to learn rate
// - red indicator flashes twice then pauses while rate learning runs
// - requests may be ignored while learning; requester retries
// - learning ends, rate kept, after Who-Is or ReadProperty fully processed
// - learning restarts after every power cycle and station address change
// - default object id is vendor prefix plus station address, tracking changes
// - a network-written object id is stored and no longer tracks address
// - new max master and max info frames apply only after reset
// - only station addresses 1 to 127 are valid
// - new address applies after switches unchanged for 15 seconds
// - invalid address: red indicator flashes once, device stays off network
// - on address change, stop answering the old address at once
`include "abslc_defines.vh"

module abslc_link_cfg #(
	parameter SETTLE_CYCLES   = `ABSLC_SETTLE_CYCLES,
	parameter LED_SLOT_CYCLES = `ABSLC_LED_SLOT_CYCLES
) (
	input  wire        clk,
	input  wire        rstn,
	input  wire        rs485_rx,
	input  wire [7:0]  station_address_switch_bank,
	input  wire        req_done,
	input  wire [7:0]  tx_data,
	input  wire        tx_valid,
	input  wire        oid_wr,
	input  wire [21:0] oid_wr_data,
	input  wire        nv_oid_fixed,
	input  wire [21:0] nv_oid,
	input  wire        max_master_wr,
	input  wire [6:0]  max_master_wr_data,
	input  wire        max_info_wr,
	input  wire [7:0]  max_info_wr_data,
	input  wire [6:0]  nv_max_master,
	input  wire [7:0]  nv_max_info,
	output reg  [7:0]  rx_data_q,
	output reg         rx_valid_q,
	output reg         rx_frame_err_q,
	output reg         tx_ready_q,
	output reg         rs485_tx_q,
	output reg         rs485_tx_en_q,
	output reg  [6:0]  station_addr_q,
	output reg         addr_valid_q,
	output reg         net_enable_q,
	output reg         learning_q,
	output reg         locked_q,
	output reg  [15:0] bit_div_q,
	output reg         red_led_q,
	output reg  [21:0] object_id_q,
	output reg         oid_fixed_q,
	output reg         oid_save_q,
	output reg  [6:0]  max_master_q,
	output reg  [7:0]  max_info_q,
	output reg  [6:0]  max_master_pend_q,
	output reg  [7:0]  max_info_pend_q,
	output reg         cfg_save_q
);

	localparam RX_IDLE  = 2'b00;
	localparam RX_START = 2'b01;
	localparam RX_DATA  = 2'b10;
	localparam RX_STOP  = 2'b11;

	function addr_ok;
		input [7:0] a;
		begin
			addr_ok = (a >= `ABSLC_ADDR_MIN) && (a <= `ABSLC_ADDR_MAX);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	reg        rx_m_q;
	reg        rx_s_q;
	reg [7:0]  sw_m_q;
	reg [7:0]  sw_s_q;

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx_m_q <= 1'b1;
			rx_s_q <= 1'b1;
			sw_m_q <= 8'h00;
			sw_s_q <= 8'h00;
		end else begin
			rx_m_q <= rs485_rx;
			rx_s_q <= rx_m_q;
			sw_m_q <= station_address_switch_bank;
			sw_s_q <= sw_m_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// station address settle and learning control

	reg [1:0]  boot_q;
	reg [7:0]  sw_last_q;
	reg [30:0] settle_q;
	reg        settle_busy_q;
	reg        restart_q;
	wire [15:0] meas_w;
	wire [15:0] div_w  = locked_q ? bit_div_q : meas_w;
	wire        div_ok = (div_w >= `ABSLC_DIV_MIN) && (div_w != `ABSLC_DIV_NONE);

	abslc_pulse_meter u_meter (
		.clk         (clk),
		.rstn        (rstn),
		.rx_s        (rx_s_q),
		.clear       (restart_q),
		.enable      (learning_q),
		.min_width_q (meas_w)
	);

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			boot_q         <= 2'h0;
			sw_last_q      <= 8'h00;
			settle_q       <= 31'h00000000;
			settle_busy_q  <= 1'b0;
			restart_q      <= 1'b0;
			station_addr_q <= 7'h00;
			addr_valid_q   <= 1'b0;
			net_enable_q   <= 1'b0;
			learning_q     <= 1'b0;
			locked_q       <= 1'b0;
			bit_div_q      <= `ABSLC_DIV_NONE;
		end else begin
			restart_q <= 1'b0;
			if (boot_q != 2'h3) begin
				// wait for the switch synchroniser to fill, then apply at once
				boot_q <= boot_q + 2'h1;
				if (boot_q == 2'h2) begin
					sw_last_q      <= sw_s_q;
					station_addr_q <= sw_s_q[6:0];
					addr_valid_q   <= addr_ok(sw_s_q);
					net_enable_q   <= addr_ok(sw_s_q);
					learning_q     <= addr_ok(sw_s_q);
					restart_q      <= 1'b1;
				end
			end else if (sw_s_q != sw_last_q) begin
				// any movement drops the old address immediately
				sw_last_q     <= sw_s_q;
				settle_q      <= 31'h00000000;
				settle_busy_q <= 1'b1;
				net_enable_q  <= 1'b0;
			end else if (settle_busy_q) begin
				if (settle_q == SETTLE_CYCLES[30:0] - 31'h1) begin
					settle_busy_q  <= 1'b0;
					station_addr_q <= sw_s_q[6:0];
					addr_valid_q   <= addr_ok(sw_s_q);
					net_enable_q   <= addr_ok(sw_s_q);
					learning_q     <= addr_ok(sw_s_q);
					locked_q       <= 1'b0;
					bit_div_q      <= `ABSLC_DIV_NONE;
					restart_q      <= 1'b1;
				end else begin
					settle_q <= settle_q + 31'h1;
				end
			end else if (learning_q && req_done && div_ok) begin
				// the processed request proves the measured rate
				learning_q <= 1'b0;
				locked_q   <= 1'b1;
				bit_div_q  <= meas_w;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// receiver, 8N1, sampling at mid bit

	reg [1:0]  rx_st_q;
	reg [15:0] rx_cnt_q;
	reg [2:0]  rx_bit_q;
	reg [7:0]  rx_sh_q;

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx_st_q        <= RX_IDLE;
			rx_cnt_q       <= 16'h0000;
			rx_bit_q       <= 3'h0;
			rx_sh_q        <= 8'h00;
			rx_data_q      <= 8'h00;
			rx_valid_q     <= 1'b0;
			rx_frame_err_q <= 1'b0;
		end else begin
			rx_valid_q     <= 1'b0;
			rx_frame_err_q <= 1'b0;
			case (rx_st_q)
			RX_IDLE: begin
				// a provisional rate may misframe, so early requests can be lost
				if (!rx_s_q && div_ok && !restart_q) begin
					rx_st_q  <= RX_START;
					rx_cnt_q <= {1'b0, div_w[15:1]};
				end
			end
			RX_START: begin
				if (rx_cnt_q != 16'h0000) begin
					rx_cnt_q <= rx_cnt_q - 16'h0001;
				end else if (!rx_s_q) begin
					rx_st_q  <= RX_DATA;
					rx_cnt_q <= div_w - 16'h0001;
					rx_bit_q <= 3'h0;
				end else begin
					rx_st_q <= RX_IDLE;
				end
			end
			RX_DATA: begin
				if (rx_cnt_q != 16'h0000) begin
					rx_cnt_q <= rx_cnt_q - 16'h0001;
				end else begin
					rx_sh_q  <= {rx_s_q, rx_sh_q[7:1]};
					rx_cnt_q <= div_w - 16'h0001;
					rx_bit_q <= rx_bit_q + 3'h1;
					// no parity bit follows the eighth data bit
					if (rx_bit_q == `ABSLC_DATA_BITS)
						rx_st_q <= RX_STOP;
				end
			end
			default: begin
				if (rx_cnt_q != 16'h0000) begin
					rx_cnt_q <= rx_cnt_q - 16'h0001;
				end else begin
					rx_st_q        <= RX_IDLE;
					rx_data_q      <= rx_sh_q;
					rx_valid_q     <= rx_s_q;
					rx_frame_err_q <= ~rx_s_q;
				end
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// transmitter: start, 8 data lsb first, one stop

	reg [9:0]  tx_sh_q;
	reg [15:0] tx_cnt_q;
	reg [3:0]  tx_nb_q;
	reg        tx_busy_q;

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_sh_q       <= 10'h3FF;
			tx_cnt_q      <= 16'h0000;
			tx_nb_q       <= 4'h0;
			tx_busy_q     <= 1'b0;
			tx_ready_q    <= 1'b0;
			rs485_tx_q    <= 1'b1;
			rs485_tx_en_q <= 1'b0;
		end else begin
			if (tx_valid && tx_ready_q) begin
				tx_sh_q       <= {1'b1, tx_data, 1'b0};
				tx_cnt_q      <= div_w - 16'h0001;
				tx_nb_q       <= 4'h0;
				tx_busy_q     <= 1'b1;
				tx_ready_q    <= 1'b0;
				rs485_tx_en_q <= 1'b1;
				rs485_tx_q    <= 1'b0;
			end else if (tx_busy_q) begin
				if (tx_cnt_q != 16'h0000) begin
					tx_cnt_q <= tx_cnt_q - 16'h0001;
				end else if (tx_nb_q == 4'h9) begin
					tx_busy_q     <= 1'b0;
					rs485_tx_en_q <= 1'b0;
					rs485_tx_q    <= 1'b1;
				end else begin
					// divider reread from div_w every bit; fixed only once locked
					tx_cnt_q   <= div_w - 16'h0001;
					tx_nb_q    <= tx_nb_q + 4'h1;
					tx_sh_q    <= {1'b1, tx_sh_q[9:1]};
					rs485_tx_q <= tx_sh_q[1];
				end
			end else begin
				// no answers off the network or without a usable rate
				tx_ready_q <= net_enable_q & div_ok;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// red indicator: eight slots, flashes on even slots

	reg [31:0] slot_cnt_q;
	reg [2:0]  slot_q;
	reg [1:0]  nflash_d;

	always @* begin
		nflash_d = `ABSLC_LED_NONE;
		if (!addr_valid_q)
			nflash_d = `ABSLC_LED_INVALID;
		else if (learning_q)
			nflash_d = `ABSLC_LED_LEARN;
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			slot_cnt_q <= 32'h00000000;
			slot_q     <= 3'h0;
			red_led_q  <= 1'b0;
		end else begin
			if (slot_cnt_q == LED_SLOT_CYCLES[31:0] - 32'h1) begin
				slot_cnt_q <= 32'h00000000;
				slot_q     <= slot_q + 3'h1;
			end else begin
				slot_cnt_q <= slot_cnt_q + 32'h1;
			end
			red_led_q <= ~slot_q[0] && ({1'b0, slot_q[2:1]} < {1'b0, nflash_d});
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// object identifier and token limits

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			object_id_q       <= 22'h000000;
			oid_fixed_q       <= 1'b0;
			oid_save_q        <= 1'b0;
			max_master_q      <= 7'h00;
			max_info_q        <= 8'h00;
			max_master_pend_q <= 7'h00;
			max_info_pend_q   <= 8'h00;
			cfg_save_q        <= 1'b0;
		end else begin
			oid_save_q <= 1'b0;
			cfg_save_q <= 1'b0;
			if (boot_q == 2'h0) begin
				// stored settings only take effect here, after a reset
				oid_fixed_q       <= nv_oid_fixed;
				object_id_q       <= nv_oid;
				max_master_q      <= nv_max_master;
				max_info_q        <= nv_max_info;
				max_master_pend_q <= nv_max_master;
				max_info_pend_q   <= nv_max_info;
			end else if (oid_wr) begin
				oid_fixed_q <= 1'b1;
				object_id_q <= oid_wr_data;
				oid_save_q  <= 1'b1;
			end else if (!oid_fixed_q) begin
				object_id_q <= `ABSLC_OID_PREFIX + {15'h0000, station_addr_q};
			end
			if (boot_q != 2'h0 && max_master_wr) begin
				max_master_pend_q <= max_master_wr_data;
				cfg_save_q        <= 1'b1;
			end
			if (boot_q != 2'h0 && max_info_wr) begin
				max_info_pend_q <= max_info_wr_data;
				cfg_save_q      <= 1'b1;
			end
		end
	end

endmodule

// file: bench/abslc_link_cfg_sva.sv
// port assertions for the link configuration block
`include "abslc_defines.vh"
module abslc_link_cfg_sva #(
	parameter SETTLE_CYCLES   = 200,
	parameter LED_SLOT_CYCLES = 8
) (
	input wire        clk,
	input wire        rstn,
	input wire [7:0]  station_address_switch_bank,
	input wire        req_done,
	input wire        tx_valid,
	input wire        oid_wr,
	input wire [21:0] oid_wr_data,
	input wire        max_master_wr,
	input wire [6:0]  max_master_wr_data,
	input wire        tx_ready_q,
	input wire        rs485_tx_q,
	input wire        rs485_tx_en_q,
	input wire [6:0]  station_addr_q,
	input wire        addr_valid_q,
	input wire        net_enable_q,
	input wire        learning_q,
	input wire        locked_q,
	input wire [15:0] bit_div_q,
	input wire [21:0] object_id_q,
	input wire        oid_fixed_q,
	input wire        oid_save_q,
	input wire [6:0]  max_master_q,
	input wire [7:0]  max_info_q,
	input wire [6:0]  max_master_pend_q,
	input wire        cfg_save_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// startup edges load stored state, so hold-type checks wait for them
	reg [1:0] age_q;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) age_q <= 2'h0;
		else if (age_q != 2'h3) age_q <= age_q + 2'h1;
	end
	a_tx_start: assert property (tx_valid && tx_ready_q |=> rs485_tx_en_q && !rs485_tx_q)
		else $error("start bit missing after accept");
	a_tx_idle: assert property (!rs485_tx_en_q |-> rs485_tx_q)
		else $error("line not idle high");
	a_lock_cause: assert property ($rose(locked_q) |-> $past(req_done) && !learning_q)
		else $error("lock without processed request");
	a_lock_div: assert property (locked_q |-> bit_div_q >= 16'h0010 && bit_div_q != 16'hFFFF)
		else $error("locked divider unusable");
	a_rate_kept: assert property (locked_q && $past(locked_q) |-> $stable(bit_div_q))
		else $error("learned rate moved");
	a_addr_range: assert property (addr_valid_q |-> station_addr_q != 7'h00)
		else $error("address zero flagged valid");
	a_old_addr: assert property (!$stable(station_address_switch_bank) |-> ##[1:5] !net_enable_q)
		else $error("old address still answered");
	a_oid_track: assert property (age_q == 2'h3 && !oid_fixed_q
		|-> object_id_q == `ABSLC_OID_PREFIX + $past(station_addr_q))
		else $error("default id not tracking");
	a_oid_write: assert property (oid_wr |=> object_id_q == $past(oid_wr_data) && oid_fixed_q
		&& oid_save_q)
		else $error("written id not taken");
	a_oid_hold: assert property (age_q == 2'h3 && oid_fixed_q && !$past(oid_wr)
		|-> $stable(object_id_q))
		else $error("fixed id changed");
	a_pend_write: assert property (max_master_wr |=> max_master_pend_q == $past(max_master_wr_data)
		&& cfg_save_q)
		else $error("limit write not pending");
	a_limits_fixed: assert property (age_q == 2'h3 |-> $stable(max_master_q) && $stable(max_info_q))
		else $error("limit changed without reset");
endmodule

// file: bench/abslc_node_model.sv
// far bus node: sends and receives 8N1 characters
module abslc_node_model (
	input  wire  clk,
	input  wire  tx,
	input  wire  tx_en,
	output logic line
);
	timeunit 1ns;
	timeprecision 1ps;
	initial line = 1'b1;
	// caller enters just after an edge; biased bus idles high
	task automatic send(input logic [7:0] b, input int per);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line = f[i];
			repeat (per) @(posedge clk);
			#1;
		end
	endtask
	task automatic recv(input int per, output logic [7:0] b);
		int n;
		b = 8'hFF;
		n = 0;
		while (tx_en !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		repeat (per / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (per) @(posedge clk);
			b[i] = tx;
		end
	endtask
	// holds the line low for n cycles, a character with a low stop bit
	task automatic hold_low(input int n);
		line = 1'b0;
		repeat (n) @(posedge clk);
		#1;
		line = 1'b1;
	endtask
endmodule

// file: bench/test_abslc_link_cfg.sv
// self-checking bench for the link configuration block
`include "abslc_defines.vh"
module test_abslc_link_cfg;
	timeunit 1ns;
	timeprecision 1ps;
	localparam SC = 200;
	localparam LS = 8;
	logic clk, rstn, req_done, tx_valid, oid_wr, nv_oid_fixed, max_master_wr, max_info_wr;
	logic [7:0] station_address_switch_bank, tx_data, max_info_wr_data, nv_max_info, got, b;
	logic [21:0] oid_wr_data, nv_oid;
	logic [6:0] max_master_wr_data, nv_max_master;
	wire rs485_rx, rx_valid_q, rx_frame_err_q, tx_ready_q, rs485_tx_q, rs485_tx_en_q;
	wire addr_valid_q, net_enable_q, learning_q, locked_q, red_led_q, oid_fixed_q;
	wire oid_save_q, cfg_save_q;
	wire [7:0] rx_data_q, max_info_q, max_info_pend_q;
	wire [6:0] station_addr_q, max_master_q, max_master_pend_q;
	wire [15:0] bit_div_q;
	wire [21:0] object_id_q;
	int fails, comparisons, i, nrx, nerr;
	abslc_link_cfg #(.SETTLE_CYCLES(SC), .LED_SLOT_CYCLES(LS)) dut (.*);
	abslc_node_model node (.clk(clk), .tx(rs485_tx_q), .tx_en(rs485_tx_en_q), .line(rs485_rx));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		if (rx_valid_q === 1'b1) begin
			got <= rx_data_q;
			nrx <= nrx + 1;
		end
		if (rx_frame_err_q === 1'b1)
			nerr <= nerr + 1;
	end
	task automatic close_out;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic do_reset;
		rstn = 1'b0;
		tk(2);
		rstn = 1'b1;
	endtask
	// led pattern repeats every eight slots, so count rising edges over one period
	task automatic flashes(input int exp);
		int n;
		logic p;
		n = 0;
		p = red_led_q;
		repeat (8 * LS) begin
			tk(1);
			if (red_led_q === 1'b1 && p !== 1'b1) n++;
			p = red_led_q;
		end
		chk(n, exp);
	endtask
	task automatic settle(input logic [7:0] a);
		station_address_switch_bank = a;
		tk(SC + 20);
	endtask
	task automatic t_start;
		chk(rs485_tx_q, 1'b1);
		chk(bit_div_q, 16'hFFFF);
		tk(4);
		chk(max_master_q, 7'h7F);
		chk(learning_q, 1'b1);
		chk(object_id_q, `ABSLC_OID_PREFIX + 22'h000005);
		flashes(2);
	endtask
	task automatic t_learn;
		int n0;
		// rate still unknown: these may be misframed and go unanswered
		node.send(8'h55, 32);
		node.send(8'h55, 32);
		// idle gap lets a misframed receiver fall back to idle
		tk(12 * 32);
		n0 = nrx;
		node.send(8'hC3, 32);
		for (i = 0; i < 64 && nrx == n0; i++) tk(1);
		chk(got, 8'hC3);
		req_done = 1'b1;
		tk(1);
		req_done = 1'b0;
		chk(locked_q, 1'b1);
		chk(learning_q, 1'b0);
		chk(bit_div_q >= 16'h001E && bit_div_q <= 16'h0022, 1'b1);
	endtask
	task automatic t_tx;
		tk(4);
		tx_data = 8'h3C;
		tx_valid = 1'b1;
		fork
			node.recv(bit_div_q, b);
			begin
				for (i = 0; i < 50 && tx_ready_q !== 1'b1; i++) tk(1);
				tk(1);
				tx_valid = 1'b0;
			end
		join
		chk(b, 8'h3C);
	endtask
	// a character whose stop bit is low is flagged, not delivered
	task automatic t_break;
		int e0;
		e0 = nerr;
		node.hold_low(10 * 32);
		tk(64);
		chk(nerr - e0, 1);
	endtask
	task automatic t_oid;
		oid_wr_data = 22'h012345;
		oid_wr = 1'b1;
		tk(1);
		oid_wr = 1'b0;
		chk({object_id_q, oid_fixed_q, oid_save_q}, {22'h012345, 2'h3});
	endtask
	task automatic t_addr;
		station_address_switch_bank = 8'h09;
		tk(6);
		chk({net_enable_q, tx_ready_q}, 2'h0);
		tk(100);
		chk(station_addr_q, 7'h05);
		for (i = 0; i < 400 && station_addr_q !== 7'h09; i++) tk(1);
		if (i == 400) begin
			fails++;
			close_out;
		end
		chk(station_addr_q, 7'h09);
		chk(i, SC - 103);
		tk(2);
		chk({learning_q, locked_q}, 2'h2);
		chk(object_id_q, 22'h012345);
	endtask
	task automatic t_invalid;
		logic [7:0] v [2];
		v = '{8'h00, 8'h80};
		foreach (v[k]) begin
			settle(v[k]);
			chk({addr_valid_q, net_enable_q, tx_ready_q}, 3'h0);
			flashes(1);
		end
		settle(8'h7F);
		chk(addr_valid_q, 1'b1);
	endtask
	task automatic t_limits;
		max_master_wr_data = 7'h20;
		max_info_wr_data = 8'h40;
		max_master_wr = 1'b1;
		max_info_wr = 1'b1;
		tk(1);
		max_master_wr = 1'b0;
		max_info_wr = 1'b0;
		chk({max_master_pend_q, max_info_pend_q, cfg_save_q}, {7'h20, 8'h40, 1'b1});
		chk(max_master_q, 7'h7F);
		nv_max_master = max_master_pend_q;
		nv_max_info = max_info_pend_q;
		nv_oid = object_id_q;
		nv_oid_fixed = oid_fixed_q;
		do_reset;
		tk(4);
		chk({max_master_q, max_info_q}, {7'h20, 8'h40});
		chk({object_id_q, oid_fixed_q}, {22'h012345, 1'b1});
	endtask
	initial begin
		{req_done, tx_valid, oid_wr, nv_oid_fixed, max_master_wr, max_info_wr} = 6'h00;
		{tx_data, max_info_wr_data, oid_wr_data, nv_oid, max_master_wr_data} = 67'h0;
		station_address_switch_bank = 8'h05;
		nv_max_master = 7'h7F;
		nv_max_info = 8'h01;
		fails = 0;
		comparisons = 0;
		nrx = 0;
		nerr = 0;
		got = 8'h00;
		do_reset;
		t_start;
		t_learn;
		t_tx;
		t_break;
		t_oid;
		t_addr;
		t_invalid;
		t_limits;
		close_out;
	end
	initial begin
		repeat (100000) @(posedge clk);
		fails++;
		close_out;
	end
endmodule
bind abslc_link_cfg abslc_link_cfg_sva #(.SETTLE_CYCLES(SETTLE_CYCLES),
	.LED_SLOT_CYCLES(LED_SLOT_CYCLES)) u_sva (.clk, .rstn, .station_address_switch_bank,
	.req_done, .tx_valid, .oid_wr, .oid_wr_data, .max_master_wr, .max_master_wr_data,
	.tx_ready_q, .rs485_tx_q, .rs485_tx_en_q, .station_addr_q, .addr_valid_q, .net_enable_q,
	.learning_q, .locked_q, .bit_div_q, .object_id_q, .oid_fixed_q, .oid_save_q,
	.max_master_q, .max_info_q, .max_master_pend_q, .cfg_save_q);
